// >>> src/tmc_pkg.sv
package tmc_pkg;

    // host i/o port map
    localparam logic [9:0] PORT_WORD0    = 10'h220;
    localparam logic [9:0] PORT_WORD1    = 10'h221;
    localparam logic [9:0] PORT_WORD2    = 10'h222;
    localparam logic [9:0] PORT_WORD3    = 10'h223;
    localparam logic [9:0] PORT_CMD_SET  = 10'h226;
    localparam logic [9:0] PORT_FLAGS    = 10'h227;

    // handshake flag positions in the flag port
    localparam int FLAG_ATTN_BIT = 7;
    localparam int FLAG_CREQ_BIT = 6;

    // main status bit positions
    localparam int ST_AUX_CHG   = 7;
    localparam int ST_TRIG      = 6;
    localparam int ST_KEY_EMPTY = 5;
    localparam int ST_UNIT_RST  = 3;
    localparam int ST_CMD_IRQ   = 2;
    localparam int ST_BUF_MOD   = 1;
    localparam int ST_CURSOR    = 0;

    // bits that only a clear command can drop
    localparam logic [7:0] ST_STICKY_MASK = 8'hCB;
    localparam logic [7:0] ST_RESET_VAL   = 8'h24;

    // buffer geometry
    localparam int BUF_ROWS  = 25;
    localparam int BUF_COLS  = 80;
    localparam int BUF_DEPTH = BUF_ROWS * BUF_COLS;
    localparam int ADDR_W    = 11;
    localparam int ADDR_HI_W = 3;

    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [3:0] {
        TMC_CMD_READ_BUF   = 4'h0,
        TMC_CMD_WRITE_BUF  = 4'h1,
        TMC_CMD_READ_STAT  = 4'h2,
        TMC_CMD_CLR_STAT   = 4'h3,
        TMC_CMD_KEYSTROKE  = 4'h4,
        TMC_CMD_LIGHT_PEN  = 4'h5,
        TMC_CMD_POWER_RST  = 4'h6,
        TMC_CMD_TRIG_DATA  = 4'h7,
        TMC_CMD_TRIG_ADDR  = 4'h8,
        TMC_CMD_ATTN_MASK  = 4'h9
    } tmc_cmd_t;

    typedef enum logic [0:0] {
        TMC_ST_IDLE = 1'b0,
        TMC_ST_EXEC = 1'b1
    } tmc_state_t;

endpackage : tmc_pkg

// >>> src/tmc_trig_if.sv
`timescale 1ns/1ns
interface tmc_trig_if;
    logic [7:0] watched;
    logic       load_cfg;
    logic [7:0] new_data;
    logic [7:0] new_mask;
    logic       snap;
    logic       hit;

    modport ctrl (output watched, output load_cfg, output new_data, output new_mask,
                  output snap, input hit);
    modport unit (input watched, input load_cfg, input new_data, input new_mask,
                  input snap, output hit);
endinterface : tmc_trig_if

// >>> src/tmc_trigger.sv
`timescale 1ns/1ns
module tmc_trigger
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // compare set-up and result
    tmc_trig_if.unit  trg
);

    logic [7:0] data_q;
    logic [7:0] mask_q;
    logic [7:0] snap_q;

    // compare data and mask, mask starts at zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_q <= BYTE_ZERO;
            mask_q <= BYTE_ZERO;
        end else if (trg.load_cfg) begin
            data_q <= trg.new_data;
            mask_q <= trg.new_mask;
        end
    end

    // snapshot of the watched byte for the change-of-state test
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            snap_q <= BYTE_ZERO;
        end else if (trg.snap) begin
            snap_q <= trg.watched;
        end
    end

    // zero mask means any change from the snapshot counts
    always_comb begin
        if (mask_q == BYTE_ZERO) begin
            trg.hit = (trg.watched != snap_q);
        end else begin
            trg.hit = (((trg.watched ^ data_q) & mask_q) == BYTE_ZERO);
        end
    end

endmodule : tmc_trigger

// >>> src/tmc_top.sv
`timescale 1ns/1ns
module tmc_top
    import tmc_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // host i/o bus
    input  wire logic [9:0]        io_addr,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [7:0]        io_wdata,
    output logic      [7:0]        io_rdata,
    // events from the terminal link side
    input  wire logic              ctl_buf_wr,
    input  wire logic [ADDR_W-1:0] ctl_buf_addr,
    input  wire logic [7:0]        ctl_buf_char,
    input  wire logic [7:0]        ctl_buf_attr,
    input  wire logic              ctl_cursor_set,
    input  wire logic [ADDR_W-1:0] ctl_cursor_addr,
    input  wire logic              ctl_unit_reset,
    input  wire logic [7:0]        ctl_aux_status,
    input  wire logic              ctl_key_taken,
    // requests toward the terminal link side
    output logic                   key_valid,
    output logic      [7:0]        key_code,
    output logic                   pen_valid,
    output logic      [7:0]        pen_row,
    output logic      [7:0]        pen_field_identifier,
    output logic                   por_request
);

    // screen buffer and its extended attribute plane
    logic [7:0] chr_mem [DEPTH];
    logic [7:0] extended_attribute_byte [DEPTH];
    // the planes are not reset; a location reads unknown until someone writes it

    tmc_state_t      state_q;
    logic            cmd_req_q;
    logic            attn_req_q;
    logic            word0_cmd_q;
    logic [7:0]      word0_q;
    logic [7:0]      word1_q;
    logic [7:0]      word2_q;
    logic [7:0]      word3_q;
    logic [7:0]      status_q;
    logic [7:0]      status_d;
    logic [7:0]      attn_mask_q;
    logic [7:0]      aux_q;
    logic [ADDR_W-1:0] cursor_q;
    logic [ADDR_W-1:0] trig_addr_q;
    logic            hit_q;
    logic            host_wr;
    logic            exec;
    logic            cmd_wr_buf;
    logic            trig_fire;
    logic [ADDR_W-1:0] word_addr;
    tmc_cmd_t        cmd;
    tmc_trig_if      trg ();

    tmc_trigger u_trigger (
        .clk  (clk),
        .nrst (nrst),
        .trg  (trg)
    );

    // decode of the executing command
    assign cmd       = tmc_cmd_t'(word0_q[3:0]);
    assign exec      = (state_q == TMC_ST_EXEC);
    assign word_addr = {word2_q[ADDR_HI_W-1:0], word1_q};
    assign host_wr   = exec && (cmd == TMC_CMD_WRITE_BUF) && (word0_q[7:4] == 4'h0);
    assign cmd_wr_buf = host_wr && (word_addr < ADDR_W'(DEPTH));

    // command sequencer: one edge to accept, one to execute and finish
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= TMC_ST_IDLE;
        end else begin
            unique case (state_q)
                TMC_ST_IDLE: begin
                    if (cmd_req_q) begin
                        state_q <= TMC_ST_EXEC;
                    end
                end
                TMC_ST_EXEC: begin
                    state_q <= TMC_ST_IDLE;
                end
            endcase
        end
    end

    // command request: host sets, device clears at the end, a set in that cycle wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_req_q <= 1'b0;
        end else if (io_wr && io_addr == PORT_CMD_SET) begin
            cmd_req_q <= 1'b1;
        end else if (exec) begin
            cmd_req_q <= 1'b0;
        end
    end

    // attention: device only sets, host only clears, set wins a tie
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            attn_req_q <= 1'b0;
        end else if (|((status_d & ~status_q) & attn_mask_q)) begin
            attn_req_q <= 1'b1;
        end else if (io_wr && io_addr == PORT_FLAGS) begin
            attn_req_q <= 1'b0;
        end
    end

    // attention mask from word three on command nine
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            attn_mask_q <= BYTE_ZERO;
        end else if (exec && word0_q == 8'(TMC_CMD_ATTN_MASK)) begin
            attn_mask_q <= word3_q;
        end
    end

    // trigger location and edge of the compare result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trig_addr_q <= '0;
            hit_q       <= 1'b0;
        end else begin
            hit_q <= trg.hit;
            if (exec && word0_q == 8'(TMC_CMD_TRIG_ADDR)) begin
                trig_addr_q <= word_addr;
            end
        end
    end

    // trigger unit hook-up; the snapshot is retaken whenever data or address loads
    always_comb begin
        trg.watched  = (trig_addr_q < ADDR_W'(DEPTH)) ? chr_mem[trig_addr_q] : BYTE_ZERO;
        trg.load_cfg = exec && (word0_q == 8'(TMC_CMD_TRIG_DATA));
        trg.new_data = word1_q;
        trg.new_mask = word2_q;
        trg.snap     = exec &&
                       (word0_q == 8'(TMC_CMD_TRIG_DATA) || word0_q == 8'(TMC_CMD_TRIG_ADDR));
    end
    // a change seen right at load would look like a trigger, so fire only on a rising edge
    assign trig_fire = trg.hit && !hit_q && !trg.snap && !trg.load_cfg;

    // cursor and aux status mirrors of the controller side
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cursor_q <= '0;
            aux_q    <= BYTE_ZERO;
        end else begin
            aux_q <= ctl_aux_status;
            if (ctl_cursor_set) begin
                cursor_q <= ctl_cursor_addr;
            end
        end
    end

    // next main status: events set, clear command drops, a set in the same cycle wins
    always_comb begin
        status_d = status_q;
        if (exec && word0_q == 8'(TMC_CMD_CLR_STAT)) begin
            status_d = status_d & ~(word3_q & ST_STICKY_MASK);
        end
        if (state_q == TMC_ST_IDLE && cmd_req_q) begin
            status_d[ST_CMD_IRQ] = 1'b0;
        end
        if (exec) begin
            status_d[ST_CMD_IRQ] = 1'b1;
        end
        // the host only sends a key while empty, so a taken pulse and a send never meet
        if (ctl_key_taken) begin
            status_d[ST_KEY_EMPTY] = 1'b1;
        end else if (exec && word0_q == 8'(TMC_CMD_KEYSTROKE)) begin
            status_d[ST_KEY_EMPTY] = 1'b0;
        end
        // sticky events
        if (aux_q != ctl_aux_status) begin
            status_d[ST_AUX_CHG] = 1'b1;
        end
        if (trig_fire) begin
            status_d[ST_TRIG] = 1'b1;
        end
        if (ctl_unit_reset) begin
            status_d[ST_UNIT_RST] = 1'b1;
        end
        if (ctl_buf_wr || cmd_wr_buf) begin
            status_d[ST_BUF_MOD] = 1'b1;
        end
        if (ctl_cursor_set) begin
            status_d[ST_CURSOR] = 1'b1;
        end
        // bit four is unused and always reads back as zero
        status_d[4] = 1'b0;
    end

    // main status; comes out of reset with key empty and the command irq up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= ST_RESET_VAL;
        end else begin
            status_q <= status_d;
        end
    end

    // buffer writes; a host write in the same cycle as the controller lands last
    always_ff @(posedge clk) begin
        if (ctl_buf_wr && ctl_buf_addr < ADDR_W'(DEPTH)) begin
            chr_mem[ctl_buf_addr]                 <= ctl_buf_char;
            extended_attribute_byte[ctl_buf_addr] <= ctl_buf_attr;
        end
        if (cmd_wr_buf) begin
            chr_mem[word_addr] <= word3_q;
        end
    end

    // word zero: host writes the code, completion hands it back to live status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word0_q     <= BYTE_ZERO;
            word0_cmd_q <= 1'b0;
        end else if (io_wr && io_addr == PORT_WORD0) begin
            word0_q     <= io_wdata;
            word0_cmd_q <= 1'b1;
        end else if (exec) begin
            word0_cmd_q <= 1'b0;
        end
    end

    // argument words; host writes, command results overwrite on completion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word1_q <= BYTE_ZERO;
            word2_q <= BYTE_ZERO;
            word3_q <= BYTE_ZERO;
        end else if (exec) begin
            unique case (word0_q)
                8'(TMC_CMD_READ_BUF): begin
                    if (word_addr < ADDR_W'(DEPTH)) begin
                        word2_q <= extended_attribute_byte[word_addr];
                        word3_q <= chr_mem[word_addr];
                    end else begin
                        word2_q <= BYTE_ZERO;
                        word3_q <= BYTE_ZERO;
                    end
                end
                8'(TMC_CMD_READ_STAT): begin
                    word1_q <= cursor_q[7:0];
                    word2_q <= {5'h00, cursor_q[ADDR_W-1:8]};
                    word3_q <= aux_q;
                end
                default: begin
                    // other codes, known or not, leave the words alone
                end
            endcase
        end else if (io_wr) begin
            if (io_addr == PORT_WORD1) begin
                word1_q <= io_wdata;
            end
            if (io_addr == PORT_WORD2) begin
                word2_q <= io_wdata;
            end
            if (io_addr == PORT_WORD3) begin
                word3_q <= io_wdata;
            end
        end
    end

    // one-cycle requests toward the controller, data held until the next request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            key_valid            <= 1'b0;
            key_code             <= BYTE_ZERO;
            pen_valid            <= 1'b0;
            pen_row              <= BYTE_ZERO;
            pen_field_identifier <= BYTE_ZERO;
            por_request          <= 1'b0;
        end else begin
            key_valid   <= exec && word0_q == 8'(TMC_CMD_KEYSTROKE);
            pen_valid   <= exec && word0_q == 8'(TMC_CMD_LIGHT_PEN);
            por_request <= exec && word0_q == 8'(TMC_CMD_POWER_RST);
            if (exec && word0_q == 8'(TMC_CMD_KEYSTROKE)) begin
                key_code <= word3_q;
            end
            if (exec && word0_q == 8'(TMC_CMD_LIGHT_PEN)) begin
                pen_row              <= word1_q;
                pen_field_identifier <= word2_q;
            end
        end
    end

    // registered i/o read data; word zero shows live status once no code is pending
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= BYTE_ZERO;
        end else if (io_rd) begin
            unique case (io_addr)
                PORT_WORD0: io_rdata <= word0_cmd_q ? word0_q : status_q;
                PORT_WORD1: io_rdata <= word1_q;
                PORT_WORD2: io_rdata <= word2_q;
                PORT_WORD3: io_rdata <= word3_q;
                PORT_FLAGS: begin
                    io_rdata                <= BYTE_ZERO;
                    io_rdata[FLAG_ATTN_BIT] <= attn_req_q;
                    io_rdata[FLAG_CREQ_BIT] <= cmd_req_q;
                end
                default: io_rdata <= BYTE_ZERO;
            endcase
        end
    end

endmodule : tmc_top

// >>> test/tmc_properties.sv
`timescale 1ns/1ns
module tmc_props_chk
    import tmc_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // host bus
    input wire logic [9:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata,
    // requests toward the link
    input wire logic       key_valid,
    input wire logic [7:0] key_code,
    input wire logic       pen_valid,
    input wire logic [7:0] pen_row,
    input wire logic       por_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [3:0] since_q;

    // cycles since the last command request; saturates so long idle time never wraps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            since_q <= 4'hF;
        end else if (io_wr && io_addr == PORT_CMD_SET) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hF) begin
            since_q <= since_q + 4'h1;
        end
    end

    sequence s_rd_flags;
        io_rd && io_addr == PORT_FLAGS;
    endsequence
    sequence s_rd_hole;
        io_rd && (io_addr == 10'h224 || io_addr == 10'h225);
    endsequence

    AST_FLAG_SPARE: assert property (s_rd_flags |=> io_rdata[5:0] == 6'h00)
        else $error("flag port spare bits not zero");
    AST_HOLE_ZERO: assert property (s_rd_hole |=> io_rdata == BYTE_ZERO)
        else $error("reserved port read not zero");
    AST_KEY_PULSE: assert property (key_valid |=> !key_valid)
        else $error("key request longer than one cycle");
    AST_POR_PULSE: assert property (por_request |=> !por_request)
        else $error("reset request longer than one cycle");
    AST_KEY_HOLD: assert property (!key_valid |-> $stable(key_code))
        else $error("key code moved without a request");
    AST_PEN_HOLD: assert property (!pen_valid |-> $stable(pen_row))
        else $error("pen row moved without a request");
    AST_ONE_REQ: assert property ($onehot0({key_valid, pen_valid, por_request}))
        else $error("two link requests at once");
    AST_REQ_AFTER_GO: assert property ((key_valid || pen_valid || por_request)
        |-> since_q inside {[4'h2:4'h6]})
        else $error("link request outside a command");
    AST_RESET_QUIET: assert property ($rose(nrst) |-> io_rdata == BYTE_ZERO && !key_valid)
        else $error("outputs not idle after reset");
endmodule : tmc_props_chk

bind tmc_top tmc_props_chk u_chk (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata), .key_valid(key_valid), .key_code(key_code),
    .pen_valid(pen_valid), .pen_row(pen_row), .por_request(por_request));

// >>> test/tmc_link_model.sv
`timescale 1ns/1ns
module tmc_link_model #(
    parameter int DELAY = 40
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // requests from the unit
    input  wire logic       key_valid,
    input  wire logic [7:0] key_code,
    input  wire logic       pen_valid,
    input  wire logic [7:0] pen_row,
    input  wire logic [7:0] pen_field_identifier,
    input  wire logic       por_request,
    // answers and captures
    output logic            ctl_key_taken,
    output logic      [7:0] last_key,
    output logic      [7:0] last_row,
    output logic      [7:0] last_fid,
    output logic      [7:0] por_cnt
);
    int wait_q;

    // slow key acceptance, so the empty flag stays low long enough to be seen
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 0;
            ctl_key_taken <= 1'b0;
            last_key <= 8'h00;
        end else begin
            ctl_key_taken <= (wait_q == 1);
            if (key_valid) begin
                wait_q <= DELAY;
                last_key <= key_code;
            end else if (wait_q != 0) begin
                wait_q <= wait_q - 1;
            end
        end
    end

    // pen location and power-up requests are only recorded
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {last_row, last_fid, por_cnt} <= '0;
        end else begin
            if (pen_valid) begin
                {last_row, last_fid} <= {pen_row, pen_field_identifier};
            end
            if (por_request) begin
                por_cnt <= por_cnt + 8'h01;
            end
        end
    end
endmodule : tmc_link_model

// >>> test/tb.sv
`timescale 1ns/1ns
module tb
    import tmc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst, io_wr, io_rd, ctl_buf_wr, ctl_cursor_set, ctl_unit_reset, ctl_key_taken;
    logic key_valid, pen_valid, por_request;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata, ctl_buf_char, ctl_buf_attr, ctl_aux_status, key_code;
    logic [7:0] pen_row, pen_fid, last_key, last_row, last_fid, por_cnt, f;
    logic [ADDR_W-1:0] ctl_buf_addr, ctl_cursor_addr;
    logic [7:0] r [4];
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    tmc_top u_dut (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .ctl_buf_wr(ctl_buf_wr),
        .ctl_buf_addr(ctl_buf_addr), .ctl_buf_char(ctl_buf_char), .ctl_buf_attr(ctl_buf_attr),
        .ctl_cursor_set(ctl_cursor_set), .ctl_cursor_addr(ctl_cursor_addr),
        .ctl_unit_reset(ctl_unit_reset), .ctl_aux_status(ctl_aux_status),
        .ctl_key_taken(ctl_key_taken), .key_valid(key_valid), .key_code(key_code),
        .pen_valid(pen_valid), .pen_row(pen_row), .pen_field_identifier(pen_fid),
        .por_request(por_request));

    tmc_link_model u_link (.clk(clk), .nrst(nrst), .key_valid(key_valid), .key_code(key_code),
        .pen_valid(pen_valid), .pen_row(pen_row), .pen_field_identifier(pen_fid),
        .por_request(por_request), .ctl_key_taken(ctl_key_taken), .last_key(last_key),
        .last_row(last_row), .last_fid(last_fid), .por_cnt(por_cnt));

    task summarize;
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            summarize();
        end
    end

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task tick;
        @(posedge clk);
        #1;
    endtask : tick

    // every access starts one time unit after an edge; an idle edge separates accesses
    task wr(input logic [9:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        tick();
        io_wr = 1'b0;
        tick();
    endtask : wr

    task rd(input logic [9:0] a, output logic [7:0] d);
        io_addr = a;
        io_rd = 1'b1;
        tick();
        io_rd = 1'b0;
        d = io_rdata;
        tick();
    endtask : rd

    // load the words, raise the request, wait for it to drop, then fetch all words
    task cmd(input logic [7:0] c, input logic [7:0] w1, input logic [7:0] w2,
             input logic [7:0] w3);
        int i;
        wr(PORT_WORD1, w1);
        wr(PORT_WORD2, w2);
        wr(PORT_WORD3, w3);
        wr(PORT_WORD0, c);
        wr(PORT_CMD_SET, 8'h5A);
        for (i = 0; i < 20; i++) begin
            rd(PORT_FLAGS, f);
            if (f[FLAG_CREQ_BIT] === 1'b0)
                break;
        end
        chk("creq_clear", 8'h00, f & 8'h40);
        for (i = 0; i < 4; i++)
            rd(PORT_WORD0 + 10'(i), r[i]);
    endtask : cmd

    task ctlw(input logic [10:0] a, input logic [7:0] ch, input logic [7:0] at);
        {ctl_buf_addr, ctl_buf_char, ctl_buf_attr} = {a, ch, at};
        ctl_buf_wr = 1'b1;
        tick();
        ctl_buf_wr = 1'b0;
        tick();
    endtask : ctlw

    initial begin
        {io_wr, io_rd, ctl_buf_wr, ctl_cursor_set, ctl_unit_reset, nrst} = '0;
        {io_addr, io_wdata, ctl_buf_addr, ctl_buf_char, ctl_buf_attr} = '0;
        {ctl_cursor_addr, ctl_aux_status} = '0;
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        rd(PORT_WORD0, f);
        chk("status_rst", ST_RESET_VAL, f);
        rd(PORT_FLAGS, f);
        chk("flags_rst", 8'h00, f);
        rd(10'h224, f);
        chk("reserved", 8'h00, f);
        cmd(8'h01, 8'hCF, 8'h07, 8'hA5);
        chk("wr_status", 8'h26, r[0]);
        cmd(8'h00, 8'hCF, 8'h07, 8'h00);
        chk("rd_char_last", 8'hA5, r[3]);
        ctlw(11'h050, 8'h3C, 8'h5A);
        ctlw(11'h7D0, 8'h77, 8'h77);
        cmd(8'h00, 8'h50, 8'h00, 8'h00);
        chk("rd_attr", 8'h5A, r[2]);
        chk("rd_char", 8'h3C, r[3]);
        cmd(8'h00, 8'hD0, 8'h07, 8'h00);
        chk("rd_beyond", 8'h00, r[3]);
        cmd(8'h03, 8'h00, 8'h00, 8'hCB);
        chk("clr_status", 8'h24, r[0]);
        ctl_cursor_addr = 11'h123;
        ctl_aux_status = 8'h41;
        ctl_cursor_set = 1'b1;
        tick();
        ctl_cursor_set = 1'b0;
        repeat (3) tick();
        rd(PORT_WORD0, f);
        chk("live_status", 8'hA5, f);
        cmd(8'h02, 8'h00, 8'h00, 8'h00);
        chk("cur_lo", 8'h23, r[1]);
        chk("cur_hi", 8'h01, r[2]);
        chk("aux", 8'h41, r[3]);
        cmd(8'h03, 8'h00, 8'h00, 8'hCB);
        cmd(8'h09, 8'h00, 8'h00, 8'h08);
        ctl_unit_reset = 1'b1;
        tick();
        ctl_unit_reset = 1'b0;
        repeat (3) tick();
        rd(PORT_FLAGS, f);
        chk("attn_set", 8'h80, f);
        wr(PORT_FLAGS, 8'hFF);
        rd(PORT_FLAGS, f);
        chk("attn_clr", 8'h00, f);
        rd(PORT_WORD0, f);
        chk("sticky", 8'h2C, f);
        cmd(8'h03, 8'h00, 8'h00, 8'h08);
        chk("key_empty_before", 8'h20, r[0] & 8'h20);
        cmd(8'h04, 8'h00, 8'h00, 8'h6A);
        chk("key_busy", 8'h00, r[0] & 8'h20);
        chk("key_sent", 8'h6A, last_key);
        repeat (50) tick();
        rd(PORT_WORD0, f);
        chk("key_empty_after", 8'h20, f & 8'h20);
        cmd(8'h05, 8'h07, 8'h33, 8'h00);
        chk("pen_row", 8'h07, last_row);
        chk("pen_fid", 8'h33, last_fid);
        cmd(8'h06, 8'h00, 8'h00, 8'h00);
        chk("por", 8'h01, por_cnt);
        cmd(8'h07, 8'h3C, 8'hFF, 8'h00);
        cmd(8'h08, 8'h50, 8'h00, 8'h00);
        cmd(8'h03, 8'h00, 8'h00, 8'h40);
        chk("trig_cleared", 8'h00, r[0] & 8'h40);
        cmd(8'h01, 8'h50, 8'h00, 8'h11);
        cmd(8'h01, 8'h50, 8'h00, 8'h3C);
        repeat (4) tick();
        rd(PORT_WORD0, f);
        chk("trig_exact", 8'h40, f & 8'h40);
        cmd(8'h07, 8'h00, 8'h00, 8'h00);
        cmd(8'h08, 8'h50, 8'h00, 8'h00);
        cmd(8'h03, 8'h00, 8'h00, 8'h40);
        chk("trig_snap", 8'h00, r[0] & 8'h40);
        cmd(8'h01, 8'h50, 8'h00, 8'h3D);
        repeat (4) tick();
        rd(PORT_WORD0, f);
        chk("trig_change", 8'h40, f & 8'h40);
        cmd(8'h0F, 8'h50, 8'h00, 8'h99);
        chk("undef_irq", 8'h04, r[0] & 8'h04);
        cmd(8'h00, 8'h50, 8'h00, 8'h00);
        chk("undef_nochange", 8'h3D, r[3]);
        summarize();
    end
endmodule : tb
